// >>> design/ccev_pkg.sv
// package of constants for the comparator control and event block
//
// Function
// - bit 15 enables the comparator; setting it leaves other fields unchanged
// - clearing enable disables comparator; other fields keep their programmed values
// - bit 14 set drives result onto output pin, clear leaves pin undriven
// - bit 13 set inverts the comparator output, clear passes it through
// - inversion also feeds the edge detector, so edges swap under inversion
// - read-only bit 8 shows current result after polarity; writes ignored
// - bits 7-6 pick interrupt edges: none, rising, falling, both
// - bit 4 routes internal reference (1) or input pin A (0) to plus input
// - bits 1-0 route pin B, C, D or internal band reference to minus input
// - unimplemented bits read zero and ignore writes
`default_nettype none
package ccev_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CONTROL   = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h04;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h08;
   localparam logic [7:0] ADDR_IRQ_EN    = 8'h0c;
   // control field positions
   localparam int BIT_ENABLE   = 15;
   localparam int BIT_OUT_EN   = 14;
   localparam int BIT_INVERT   = 13;
   localparam int BIT_RESULT   = 8;
   localparam int BIT_EDGE_LO  = 6;
   localparam int BIT_POS_SEL  = 4;
   localparam int BIT_NEG_LO   = 0;
   // writable control bits: 15,14,13,7,6,4,1,0
   localparam logic [31:0] CONTROL_WMASK = 32'h0000_e0d3;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_00c3;
   // edge selection codes
   localparam logic [1:0] EDGE_NONE    = 2'h0;
   localparam logic [1:0] EDGE_RISE    = 2'h1;
   localparam logic [1:0] EDGE_FALL    = 2'h2;
   localparam logic [1:0] EDGE_BOTH    = 2'h3;
   // negative input codes
   localparam logic [1:0] NEG_PIN_B    = 2'h0;
   localparam logic [1:0] NEG_PIN_C    = 2'h1;
   localparam logic [1:0] NEG_PIN_D    = 2'h2;
   localparam logic [1:0] NEG_BAND_REF = 2'h3;
   // interrupt status bits
   localparam int IRQ_BIT_EDGE = 0;
   localparam int IRQ_WIDTH    = 1;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// >>> design/ccev_cfg_if.sv
// interface carrying configuration from the register file to the event logic
`default_nettype none
interface ccev_cfg_if;
   logic       enable;
   logic       invert;
   logic [1:0] edge_sel;
   logic       result;
   logic       edge_pulse;
   modport regs (output enable, output invert, output edge_sel, input result, input edge_pulse);
   modport evt  (input enable, input invert, input edge_sel, output result, output edge_pulse);
endinterface
`default_nettype wire

// >>> design/ccev_event.sv
// synchroniser, polarity and edge detector for the comparator result
`default_nettype none
module ccev_event
(
   input  wire logic CLK_SYS,
   input  wire logic RESET,
   input  wire logic raw_result,
   ccev_cfg_if.evt   cfg
);
   logic       sync1_reg;
   logic       sync2_reg;
   logic       sync3_reg;
   logic       stable_reg;
   logic       prev_reg;
   logic       pulse_reg;
   logic       polar;
   logic       rise;
   logic       fall;

   // three stages; only agreeing stages two and three update the level
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         sync1_reg  <= 1'b0;
         sync2_reg  <= 1'b0;
         sync3_reg  <= 1'b0;
         stable_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= raw_result;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         if (sync2_reg == sync3_reg)
            stable_reg <= sync3_reg;
      end
   end

   // inversion ahead of the detector, so inverted mode swaps edges
   assign polar = stable_reg ^ cfg.invert;
   assign rise  = polar & ~prev_reg;
   assign fall  = ~polar & prev_reg;

   // prev tracks polar always, so toggling invert while off raises no stale edge
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         prev_reg  <= 1'b0;
         pulse_reg <= 1'b0;
      end
      else
      begin
         prev_reg <= polar;
         unique case (cfg.edge_sel)
            ccev_pkg::EDGE_NONE: pulse_reg <= 1'b0;
            ccev_pkg::EDGE_RISE: pulse_reg <= cfg.enable & rise;
            ccev_pkg::EDGE_FALL: pulse_reg <= cfg.enable & fall;
            ccev_pkg::EDGE_BOTH: pulse_reg <= cfg.enable & (rise | fall);
         endcase
      end
   end

   // result reads zero while disabled, as the analog side is off
   assign cfg.result     = cfg.enable & polar;
   assign cfg.edge_pulse = pulse_reg;
endmodule
`default_nettype wire

// >>> design/ccev_top.sv
// comparator control register, axi4-lite slave, input routing and interrupt
`default_nettype none
module ccev_top
(
   input  wire logic        CLK_SYS,
   input  wire logic        RESET,
   // axi4-lite slave
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // analog side
   input  wire logic        RAW_RESULT,
   output logic             ANALOG_ENABLE,
   output logic             POS_INPUT_SELECT,
   output logic [1:0]       NEG_INPUT_SELECT,
   output logic             RESULT_PIN_OUT,
   output logic             RESULT_PIN_OE_N,
   output logic             IRQ
);
   logic [31:0]                  control_reg;
   logic [ccev_pkg::IRQ_WIDTH-1:0] irq_stat_reg;
   logic [ccev_pkg::IRQ_WIDTH-1:0] irq_en_reg;
   logic [7:0]  awaddr_reg;
   logic        aw_held_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        w_held_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rdata_reg;
   logic        do_write;
   logic [31:0] byte_mask;
   logic [31:0] control_next;
   logic [ccev_pkg::IRQ_WIDTH-1:0] clear_bits;
   logic        out_pin_reg;
   logic        oe_n_reg;

   ccev_cfg_if cfg ();

   // expands byte strobes into a bit mask
   function automatic logic [31:0] strobe_mask(input logic [3:0] s);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++)
         m[i*8 +: 8] = {8{s[i]}};
      return m;
   endfunction

   // address decode, shared by read and write paths
   function automatic logic is_mapped(input logic [7:0] a);
      return (a == ccev_pkg::ADDR_CONTROL) || (a == ccev_pkg::ADDR_IRQ_STAT) ||
             (a == ccev_pkg::ADDR_IRQ_CLEAR) || (a == ccev_pkg::ADDR_IRQ_EN);
   endfunction

   // address and data are latched separately so they may arrive in any order
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= 8'h00;
      end
      else if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
         aw_held_reg <= 1'b1;
         awaddr_reg  <= S_AXI_AWADDR;
      end
      else if (do_write)
         aw_held_reg <= 1'b0;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         w_held_reg <= 1'b0;
         wdata_reg  <= 32'h0000_0000;
         wstrb_reg  <= 4'h0;
      end
      else if (S_AXI_WVALID && S_AXI_WREADY)
      begin
         w_held_reg <= 1'b1;
         wdata_reg  <= S_AXI_WDATA;
         wstrb_reg  <= S_AXI_WSTRB;
      end
      else if (do_write)
         w_held_reg <= 1'b0;
   end

   // one write in flight: no new address or data until the response is taken
   assign S_AXI_AWREADY = ~aw_held_reg & ~bvalid_reg;
   assign S_AXI_WREADY  = ~w_held_reg & ~bvalid_reg;
   assign do_write      = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign byte_mask     = strobe_mask(wstrb_reg);

   // write response
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= ccev_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= is_mapped(awaddr_reg) ? ccev_pkg::RESP_OKAY : ccev_pkg::RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
         bvalid_reg <= 1'b0;
   end
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP  = bresp_reg;

   // only writable bits change; enable toggles never touch others
   always_comb
   begin
      control_next = control_reg;
      if (do_write && awaddr_reg == ccev_pkg::ADDR_CONTROL)
         control_next = (control_reg & ~(byte_mask & ccev_pkg::CONTROL_WMASK)) |
                        (wdata_reg & byte_mask & ccev_pkg::CONTROL_WMASK);
   end

   // control register, power-on value with ones in the edge and minus input select fields
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         control_reg <= ccev_pkg::CONTROL_RESET;
      else
         control_reg <= control_next;
   end

   // configuration toward the event logic
   assign cfg.enable   = control_reg[ccev_pkg::BIT_ENABLE];
   assign cfg.invert   = control_reg[ccev_pkg::BIT_INVERT];
   assign cfg.edge_sel = control_reg[ccev_pkg::BIT_EDGE_LO +: 2];

   ccev_event ccev_event_inst
   (
      .CLK_SYS    (CLK_SYS),
      .RESET      (RESET),
      .raw_result (RAW_RESULT),
      .cfg        (cfg)
   );

   // input routing goes straight to the analog muxes
   assign ANALOG_ENABLE    = control_reg[ccev_pkg::BIT_ENABLE];
   assign POS_INPUT_SELECT = control_reg[ccev_pkg::BIT_POS_SEL];
   assign NEG_INPUT_SELECT = control_reg[ccev_pkg::BIT_NEG_LO +: 2];

   // output pin registered; enable low means driving
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         out_pin_reg <= 1'b0;
         oe_n_reg    <= 1'b1;
      end
      else
      begin
         out_pin_reg <= cfg.result;
         oe_n_reg    <= ~control_reg[ccev_pkg::BIT_OUT_EN];
      end
   end
   assign RESULT_PIN_OUT  = out_pin_reg;
   assign RESULT_PIN_OE_N = oe_n_reg;

   // sticky status: a new edge wins over a simultaneous clear
   assign clear_bits = (do_write && awaddr_reg == ccev_pkg::ADDR_IRQ_CLEAR && wstrb_reg[0]) ?
                       wdata_reg[ccev_pkg::IRQ_WIDTH-1:0] : '0;
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         irq_stat_reg <= '0;
      else
      begin
         irq_stat_reg <= irq_stat_reg & ~clear_bits;
         if (cfg.edge_pulse)
            irq_stat_reg[ccev_pkg::IRQ_BIT_EDGE] <= 1'b1;
      end
   end

   // interrupt enable
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         irq_en_reg <= '0;
      else if (do_write && awaddr_reg == ccev_pkg::ADDR_IRQ_EN && wstrb_reg[0])
         irq_en_reg <= wdata_reg[ccev_pkg::IRQ_WIDTH-1:0];
   end
   assign IRQ = |(irq_stat_reg & irq_en_reg);

   // read channel: one read at a time, answered one cycle after the address
   assign S_AXI_ARREADY = ~rvalid_reg;
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= ccev_pkg::RESP_OKAY;
         rdata_reg  <= 32'h0000_0000;
      end
      else if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= is_mapped(S_AXI_ARADDR) ? ccev_pkg::RESP_OKAY : ccev_pkg::RESP_SLVERR;
         rdata_reg  <= 32'h0000_0000;
         unique case (S_AXI_ARADDR)
            ccev_pkg::ADDR_CONTROL:
            begin
               rdata_reg <= control_reg & ccev_pkg::CONTROL_WMASK;
               rdata_reg[ccev_pkg::BIT_RESULT] <= cfg.result;
            end
            ccev_pkg::ADDR_IRQ_STAT:
               rdata_reg[ccev_pkg::IRQ_WIDTH-1:0] <= irq_stat_reg;
            ccev_pkg::ADDR_IRQ_EN:
               rdata_reg[ccev_pkg::IRQ_WIDTH-1:0] <= irq_en_reg;
            default:
               rdata_reg <= 32'h0000_0000; // clear register is write-only
         endcase
      end
      else if (S_AXI_RREADY)
         rvalid_reg <= 1'b0;
   end
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RRESP  = rresp_reg;
   assign S_AXI_RDATA  = rdata_reg;
endmodule
`default_nettype wire

// >>> bench/ccev_assertions.sv
// port checker for the comparator control block
`default_nettype none
module ccev_assertions
(
   input wire logic        CLK_SYS,
   input wire logic        RESET,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic        ANALOG_ENABLE,
   input wire logic        POS_INPUT_SELECT,
   input wire logic [1:0]  NEG_INPUT_SELECT,
   input wire logic        RESULT_PIN_OUT,
   input wire logic        RESULT_PIN_OE_N,
   input wire logic        IRQ
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RESET);
   // bus answers and their holding
   // both halves are latched first, so the response stands two edges after the take
   wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
      && S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("no write response");
   wr_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
      && $stable(S_AXI_BRESP)) else $error("write response dropped");
   rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("no read response");
   rd_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
      && $stable(S_AXI_RDATA)) else $error("read data dropped");
   // upper read bits stay zero, config outputs move only when a write lands, pin stays low while disabled
   upper_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0)
      else $error("upper read bits set");
   en_write_a: assert property ($changed(ANALOG_ENABLE) |-> $rose(S_AXI_BVALID))
      else $error("enable moved without write");
   sel_write_a: assert property ($changed({POS_INPUT_SELECT, NEG_INPUT_SELECT})
      |-> $rose(S_AXI_BVALID)) else $error("select moved without write");
   oe_write_a: assert property ($changed(RESULT_PIN_OE_N)
      |-> S_AXI_BVALID || $past(S_AXI_BVALID)) else $error("pin enable moved alone");
   pin_off_a: assert property (!ANALOG_ENABLE [*3] |-> !RESULT_PIN_OUT)
      else $error("pin high while disabled");
   cover property ($rose(IRQ));
   cover property (S_AXI_BVALID && S_AXI_BRESP == ccev_pkg::RESP_SLVERR);
   cover property ($rose(RESULT_PIN_OUT));
endmodule
bind ccev_top ccev_assertions ccev_assertions_inst
(
   .CLK_SYS, .RESET, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
   .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
   .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .ANALOG_ENABLE, .POS_INPUT_SELECT,
   .NEG_INPUT_SELECT, .RESULT_PIN_OUT, .RESULT_PIN_OE_N, .IRQ
);
`default_nettype wire

// >>> bench/ccev_analog_model.sv
// behavioural analog comparator behind the routing selects
`default_nettype none
module ccev_analog_model
#(
   parameter logic [7:0] REF_POS = 8'h80,
   parameter logic [7:0] REF_NEG = 8'h40
)
(
   input  wire logic       enable,
   input  wire logic       pos_sel,
   input  wire logic [1:0] neg_sel,
   input  wire logic [7:0] lvl_a,
   input  wire logic [7:0] lvl_b,
   input  wire logic [7:0] lvl_c,
   input  wire logic [7:0] lvl_d,
   output logic            raw
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] vp;
   logic [7:0] vn;
   // input routing
   assign vp = pos_sel ? REF_POS : lvl_a;
   assign vn = neg_sel == 2'h0 ? lvl_b : neg_sel == 2'h1 ? lvl_c :
               neg_sel == 2'h2 ? lvl_d : REF_NEG;
   // powered down it floats: flip it so no one trusts the level
   initial raw = 1'b0;
   // an unknown level before reset is resolved too, so the bench never feeds x
   always @(enable or vp or vn)
      if (enable === 1'b1)
         raw = vp > vn;
      else
         raw = (raw !== 1'b1);
endmodule
`default_nettype wire

// >>> bench/ccev_top_tb.sv
// register-level bench for the comparator control block
`default_nettype none
module ccev_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] TBL = 4'b1101;
   logic        clk, rst, awv, wv, bready, arv, rready, lazy, inv;
   logic [7:0]  awaddr, araddr, lvl_a, lvl_b, lvl_c, lvl_d;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, nsel, rsp, code;
   logic        awr, wrd, bv, arr, rv, raw, en, psel, pout, oen, irq;
   int          n_fail = 0, samples_checked = 0, cyc = 0;
   // 50 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   ccev_top ccev_top_inst
   (
      .CLK_SYS(clk), .RESET(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
      .RAW_RESULT(raw), .ANALOG_ENABLE(en), .POS_INPUT_SELECT(psel),
      .NEG_INPUT_SELECT(nsel), .RESULT_PIN_OUT(pout), .RESULT_PIN_OE_N(oen), .IRQ(irq)
   );
   ccev_analog_model ccev_analog_model_inst
   (
      .enable(en), .pos_sel(psel), .neg_sel(nsel), .lvl_a(lvl_a), .lvl_b(lvl_b),
      .lvl_c(lvl_c), .lvl_d(lvl_d), .raw(raw)
   );
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   // ready is sampled mid-cycle, where it is settled for the next edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_t, w_t, b_t, b_s;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= !lazy;
      do
      begin
         @(negedge clk);
         aw_t = awv & awr;
         w_t = wv & wrd;
         b_s = bv;
         b_t = bv & bready;
         rsp = bresp;
         @(posedge clk);
         if (aw_t) awv <= 1'b0;
         if (w_t) wv <= 1'b0;
         if (b_s & !b_t) bready <= 1'b1;
      end
      while (!b_t);
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      logic ar_t, r_t, r_s;
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rready <= !lazy;
      do
      begin
         @(negedge clk);
         ar_t = arv & arr;
         r_s = rv;
         r_t = rv & rready;
         rd = rdata;
         rsp = rresp;
         @(posedge clk);
         if (ar_t) arv <= 1'b0;
         if (r_s & !r_t) rready <= 1'b1;
      end
      while (!r_t);
      rready <= 1'b0;
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         conclude();
      end
   end
   initial
   begin
      rst = 1'b1;
      {awv, wv, bready, arv, rready, lazy, awaddr, araddr, wdata} = '0;
      {lvl_a, lvl_b, lvl_c, lvl_d} = 32'h6010_f050;
      wstrb = 4'hf;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      axi_rd(8'h00);
      chk(rd, 32'h0000_00c3);
      chk({29'h0, oen, pout, irq}, 32'h4);
      // inverted high result reads low
      axi_wr(8'h00, 32'hffff_ffff);
      repeat (8) @(posedge clk);
      axi_rd(8'h00);
      chk(rd, 32'h0000_e0d3);
      chk({29'h0, oen, pout, psel}, 32'h1);
      chk({30'h0, nsel}, 32'h3);
      axi_wr(8'h00, 32'h0000_c0d3);
      repeat (8) @(posedge clk);
      axi_rd(8'h00);
      chk({rd[30:0], pout}, 32'h0001_83a7);
      // next access waits for the response
      axi_wr(8'h00, 32'h0000_60d3);
      axi_rd(8'h00);
      chk({rd[29:0], en, pout}, 32'h0001_834c);
      // each minus input against pin a
      for (int i = 0; i < 4; i++)
      begin
         axi_wr(8'h00, {16'h0, 8'hc0, 6'h0, 2'(i)});
         repeat (8) @(posedge clk);
         axi_rd(8'h00);
         chk(rd, {16'h0, 7'h60, TBL[i], 6'h0, 2'(i)});
         chk(32'(pout), 32'(TBL[i]));
      end
      lvl_a <= 8'h00;
      axi_wr(8'h00, 32'h0000_c013);
      repeat (8) @(posedge clk);
      axi_rd(8'h00);
      chk(rd, 32'h0000_c113);
      // every edge code, plain and inverted
      axi_wr(8'h0c, 32'h1);
      for (int k = 0; k < 8; k++)
      begin
         {inv, code} = 3'(k);
         axi_wr(8'h00, {16'h0, 2'b10, inv, 5'h0, code, 6'h0});
         repeat (8) @(posedge clk);
         axi_wr(8'h08, 32'h1);
         lvl_a <= 8'hff;
         repeat (8) @(posedge clk);
         axi_rd(8'h04);
         chk({rd[30:0], irq}, {30'h0, {2{inv ? code[1] : code[0]}}});
         axi_wr(8'h08, 32'h1);
         lvl_a <= 8'h00;
         repeat (8) @(posedge clk);
         axi_rd(8'h04);
         chk(rd, 32'(inv ? code[0] : code[1]));
         axi_wr(8'h08, 32'h1);
      end
      // masked event keeps status but not the line
      axi_wr(8'h0c, 32'h0);
      lvl_a <= 8'hff;
      repeat (8) @(posedge clk);
      axi_rd(8'h04);
      chk({rd[30:0], irq}, 32'h2);
      axi_wr(8'h0c, 32'h1);
      chk(32'(irq), 32'h1);
      axi_wr(8'h08, 32'h1);
      chk(32'(irq), 32'h0);
      axi_wr(8'h00, 32'h0000_00c0);
      axi_wr(8'h08, 32'h1);
      lvl_a <= 8'h00;
      repeat (8) @(posedge clk);
      axi_rd(8'h04);
      chk({rd[30:0], pout}, 32'h0);
      // unmapped place, slow master
      lazy = 1'b1;
      axi_wr(8'h10, 32'hffff_ffff);
      chk(32'(rsp), 32'(ccev_pkg::RESP_SLVERR));
      axi_rd(8'h10);
      chk({rd[29:0], rsp}, 32'(ccev_pkg::RESP_SLVERR));
      axi_rd(8'h00);
      chk(rd, 32'h0000_00c0);
      // enable set through one byte lane leaves the low fields alone
      wstrb <= 4'h2;
      axi_wr(8'h00, 32'h0000_8000);
      repeat (8) @(posedge clk);
      axi_rd(8'h00);
      chk(rd, 32'h0000_80c0);
      conclude();
   end
endmodule
`default_nettype wire
